// *** core/iab_pkg.sv ***
package iab_pkg;
    localparam int REG_N = 32;
    localparam int REG_AW = 5;
    localparam int DATA_W = 8;
    localparam int PC_W = 16;
    localparam int OFS_W = 12;
    localparam int STALL_W = 2;
    // status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam logic [7:0] SREG_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    localparam logic [7:0] MASK_ALL = 8'hff;
    // extra cycles beyond the accept cycle
    localparam logic [STALL_W-1:0] XTRA_NONE = 2'h0;
    localparam logic [STALL_W-1:0] XTRA_WORD = 2'h1;
    localparam logic [STALL_W-1:0] XTRA_JUMP = 2'h1;
    localparam logic [STALL_W-1:0] XTRA_CALL = 2'h2;
    localparam logic [STALL_W-1:0] XTRA_SKIP1 = 2'h1;
    localparam logic [STALL_W-1:0] XTRA_SKIP2 = 2'h2;

    typedef enum logic [4:0] {
        op_add = 5'h00,
        op_add_carry = 5'h01,
        op_add_immediate_word = 5'h02,
        op_sub = 5'h03,
        op_subtract_constant = 5'h04,
        op_subtract_with_borrow = 5'h05,
        op_subtract_constant_with_borrow = 5'h06,
        op_subtract_immediate_word = 5'h07,
        op_and = 5'h08,
        op_and_with_constant = 5'h09,
        op_or = 5'h0a,
        op_or_with_constant = 5'h0b,
        op_exclusive_or_registers = 5'h0c,
        op_set_bits_mask = 5'h0d,
        op_clear_bits_mask = 5'h0e,
        op_test_zero_negative = 5'h0f,
        op_indirect_jump = 5'h10,
        op_relative_call = 5'h11,
        op_indirect_call = 5'h12,
        op_compare_skip_equal = 5'h13,
        op_compare = 5'h14,
        op_compare_with_carry = 5'h15,
        op_compare_immediate = 5'h16
    } iab_op_e;

    typedef struct packed {
        iab_op_e op;
        logic [REG_AW-1:0] rd;
        logic [REG_AW-1:0] rr;
        logic [DATA_W-1:0] imm;
        logic [OFS_W-1:0] ofs;
    } iab_cmd_s;
endpackage : iab_pkg

// *** core/iab_core.sv ***
`timescale 1ns/1ps
// Operation
// - add registers, optional carry, flags, 1 cycle
// - add immediate to pair, flags, 2 cycles
// - subtract registers, optional borrow, 1 cycle
// - subtract constant, optional borrow, 1 cycle
// - subtract immediate from pair, 2 cycles
// - and register or constant, Z N V
// - or register or constant, Z N V
// - exclusive or registers, Z N V
// - clear bits via inverted mask, set via or
// - test register, value kept, Z N V
// - indirect jump loads pc from Z, 2 cycles
// - relative call pc plus offset plus one
// - indirect call pc from Z, 3 cycles
// - compare skip if equal, 1/2/3 cycles
// - compare updates flags, discards difference
module iab_core (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire iab_pkg::iab_cmd_s cmd,
    input wire logic next_two_word,
    output logic cmd_ready,
    input wire logic load_en,
    input wire logic [iab_pkg::REG_AW-1:0] load_addr,
    input wire logic [iab_pkg::DATA_W-1:0] load_data,
    input wire logic [iab_pkg::REG_AW-1:0] peek_addr,
    output logic [iab_pkg::DATA_W-1:0] peek_data,
    output logic [iab_pkg::PC_W-1:0] pc,
    output logic [7:0] sreg,
    output logic push_valid,
    output logic [iab_pkg::PC_W-1:0] push_pc
);
    import iab_pkg::*;

    logic [DATA_W-1:0] regs [REG_N];
    logic [7:0] sreg_reg, sreg_next;
    logic [PC_W-1:0] pc_reg, pc_next;
    logic [STALL_W-1:0] stall_reg, xtra;
    logic push_reg;
    logic [PC_W-1:0] push_pc_reg;

    // operand fetch and class decode
    wire acc = cmd_valid & cmd_ready;
    wire [DATA_W-1:0] a_val = regs[cmd.rd];
    wire [DATA_W-1:0] r_val = regs[cmd.rr];
    wire use_imm = cmd.op inside {op_subtract_constant,
        op_subtract_constant_with_borrow, op_and_with_constant,
        op_or_with_constant, op_set_bits_mask, op_clear_bits_mask,
        op_compare_immediate};
    wire carry_op = cmd.op inside {op_add_carry, op_subtract_with_borrow,
        op_subtract_constant_with_borrow, op_compare_with_carry};
    wire is_add = cmd.op inside {op_add, op_add_carry};
    wire is_cmp = cmd.op inside {op_compare, op_compare_with_carry,
        op_compare_immediate};
    wire is_sub = is_cmp | (cmd.op inside {op_sub, op_subtract_constant,
        op_subtract_with_borrow, op_subtract_constant_with_borrow});
    wire is_or = cmd.op inside {op_or, op_or_with_constant, op_set_bits_mask};
    wire is_and = cmd.op inside {op_and, op_and_with_constant,
        op_clear_bits_mask, op_test_zero_negative};
    wire is_xor = cmd.op == op_exclusive_or_registers;
    wire is_logic = is_or | is_and | is_xor;
    wire is_word = cmd.op inside {op_add_immediate_word,
        op_subtract_immediate_word};
    wire is_wsub = cmd.op == op_subtract_immediate_word;
    wire wr8 = is_add | (is_sub & ~is_cmp) | is_logic;

    // second operand: mask is 0xff minus the constant for bit clearing
    wire [DATA_W-1:0] imm_val = (cmd.op == op_clear_bits_mask) ?
        (MASK_ALL - cmd.imm) : cmd.imm;
    wire [DATA_W-1:0] b_val = (cmd.op == op_test_zero_negative) ? a_val :
        (use_imm ? imm_val : r_val);
    wire cin = carry_op & sreg_reg[FLAG_C];

    // 8-bit adder and subtractor, nine bits keep the carry out
    wire [DATA_W:0] sum9 = {1'b0, a_val} + {1'b0, b_val} + {8'h00, cin};
    wire [DATA_W:0] dif9 = {1'b0, a_val} - {1'b0, b_val} - {8'h00, cin};
    wire [4:0] nib_s = {1'b0, a_val[3:0]} + {1'b0, b_val[3:0]} + {4'h0, cin};
    wire [4:0] nib_d = {1'b0, a_val[3:0]} - {1'b0, b_val[3:0]} - {4'h0, cin};
    wire [DATA_W-1:0] ar_res = is_sub ? dif9[7:0] : sum9[7:0];
    wire ar_c = is_sub ? dif9[8] : sum9[8];
    wire ar_h = is_sub ? nib_d[4] : nib_s[4];
    wire ar_v = is_sub ? ((a_val[7] ^ b_val[7]) & (ar_res[7] ^ a_val[7])) :
        (~(a_val[7] ^ b_val[7]) & (ar_res[7] ^ a_val[7]));

    // logic unit
    wire [DATA_W-1:0] lg_res = is_or ? (a_val | b_val) :
        (is_xor ? (a_val ^ r_val) : (a_val & b_val));
    wire [DATA_W-1:0] res8 = is_logic ? lg_res : ar_res;

    // word unit on the pair, low half at the even index
    wire [REG_AW-1:0] lo_idx = {cmd.rd[4:1], 1'b0};
    wire [REG_AW-1:0] hi_idx = {cmd.rd[4:1], 1'b1};
    wire [PC_W-1:0] w_val = {regs[hi_idx], regs[lo_idx]};
    wire [PC_W-1:0] k16 = {10'h000, cmd.imm[5:0]};
    wire [PC_W:0] wsum = {1'b0, w_val} + {1'b0, k16};
    wire [PC_W:0] wdif = {1'b0, w_val} - {1'b0, k16};
    wire [PC_W-1:0] w_res = is_wsub ? wdif[15:0] : wsum[15:0];
    wire w_c = is_wsub ? wdif[16] : wsum[16];
    wire w_v = is_wsub ? (w_val[15] & ~w_res[15]) : (~w_val[15] & w_res[15]);

    // program flow targets
    wire [PC_W-1:0] z_ptr = {regs[5'h1f], regs[5'h1e]};
    wire [PC_W-1:0] pc_plus1 = pc_reg + 16'h0001;
    wire [PC_W-1:0] ofs_ext = {{(PC_W-OFS_W){cmd.ofs[OFS_W-1]}}, cmd.ofs};
    wire [PC_W-1:0] pc_rel = pc_reg + ofs_ext + 16'h0001;
    wire skip = (cmd.op == op_compare_skip_equal) && (a_val == r_val);
    wire [PC_W-1:0] pc_skip = pc_reg + (next_two_word ? 16'h0003 :
        16'h0002);
    wire is_call = cmd.op inside {op_relative_call, op_indirect_call};

    // status flag update, flow ops leave every flag untouched
    always_comb begin
        sreg_next = sreg_reg;
        if (is_add | is_sub) begin
            sreg_next[FLAG_C] = ar_c;
            sreg_next[FLAG_Z] = (ar_res == 8'h00);
            sreg_next[FLAG_N] = ar_res[7];
            sreg_next[FLAG_V] = ar_v;
            sreg_next[FLAG_H] = ar_h;
        end else if (is_logic) begin
            sreg_next[FLAG_Z] = (lg_res == 8'h00);
            sreg_next[FLAG_N] = lg_res[7];
            sreg_next[FLAG_V] = 1'b0;
        end else if (is_word) begin
            sreg_next[FLAG_C] = w_c;
            sreg_next[FLAG_Z] = (w_res == 16'h0000);
            sreg_next[FLAG_N] = w_res[15];
            sreg_next[FLAG_V] = w_v;
            sreg_next[FLAG_S] = w_res[15] ^ w_v;
        end
    end

    // next pc and the number of extra cycles the op occupies
    always_comb begin
        pc_next = pc_plus1;
        xtra = XTRA_NONE;
        case (cmd.op)
            op_add_immediate_word, op_subtract_immediate_word: begin
                xtra = XTRA_WORD;
            end
            op_indirect_jump: begin
                pc_next = z_ptr;
                xtra = XTRA_JUMP;
            end
            op_relative_call: begin
                pc_next = pc_rel;
                xtra = XTRA_CALL;
            end
            op_indirect_call: begin
                pc_next = z_ptr;
                xtra = XTRA_CALL;
            end
            op_compare_skip_equal: begin
                if (skip) begin
                    pc_next = pc_skip;
                    xtra = next_two_word ? XTRA_SKIP2 : XTRA_SKIP1;
                end
            end
            default: begin
                pc_next = pc_plus1;
            end
        endcase
    end

    assign cmd_ready = (stall_reg == XTRA_NONE);
    assign pc = pc_reg;
    assign sreg = sreg_reg;
    assign push_valid = push_reg;
    assign push_pc = push_pc_reg;
    assign peek_data = regs[peek_addr];

    // results land at the accept edge; the stall only holds off new work
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sreg_reg <= SREG_RESET;
            pc_reg <= PC_RESET;
            stall_reg <= XTRA_NONE;
        end else if (acc) begin
            sreg_reg <= sreg_next;
            pc_reg <= pc_next;
            stall_reg <= xtra;
        end else if (stall_reg != XTRA_NONE) begin
            stall_reg <= stall_reg - 2'h1;
        end
    end

    // return address toward the stack, a one-cycle push
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            push_reg <= 1'b0;
            push_pc_reg <= PC_RESET;
        end else begin
            push_reg <= acc & is_call;
            if (acc & is_call) push_pc_reg <= pc_plus1;
        end
    end

    // register file; execution beats the load port on the same entry
    for (genvar g = 0; g < REG_N; g++) begin : g_reg
        localparam logic [REG_AW-1:0] IDX = REG_AW'(g);
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) regs[g] <= REG_RESET;
            else if (acc && wr8 && cmd.rd == IDX) regs[g] <= res8;
            else if (acc && is_word && lo_idx == IDX) regs[g] <= w_res[7:0];
            else if (acc && is_word && hi_idx == IDX) regs[g] <= w_res[15:8];
            else if (load_en && load_addr == IDX) regs[g] <= load_data;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence hold_one;
        !cmd_ready ##1 cmd_ready;
    endsequence
    sequence hold_two;
        !cmd_ready [*2] ##1 cmd_ready;
    endsequence

    add_result_a: assert property (
        acc && is_add |=> regs[$past(cmd.rd)] ==
            8'($past(a_val) + $past(b_val) + {7'h00, $past(cin)}) && cmd_ready)
        else $error("add result or timing wrong");
    word_add_a: assert property (
        acc && cmd.op == op_add_immediate_word |=>
            {regs[$past(hi_idx)], regs[$past(lo_idx)]} ==
            16'($past(w_val) + $past(k16)) &&
            sreg_reg[FLAG_S] == (sreg_reg[FLAG_N] ^ sreg_reg[FLAG_V])
            ##0 hold_one)
        else $error("word add flags or timing wrong");
    sub_carry_a: assert property (
        acc && cmd.op == op_sub |=>
            sreg_reg[FLAG_C] == ($past(a_val) < $past(r_val)))
        else $error("subtract borrow wrong");
    word_sub_a: assert property (
        acc && is_wsub |=> sreg_reg[FLAG_C] ==
            ($past(w_val) < $past(k16)) ##0 hold_one)
        else $error("word subtract wrong");
    logic_flags_a: assert property (
        acc && is_logic |=> !sreg_reg[FLAG_V] &&
            sreg_reg[FLAG_C] == $past(sreg_reg[FLAG_C]))
        else $error("logic flags wrong");
    clear_bits_a: assert property (
        acc && cmd.op == op_clear_bits_mask |=>
            regs[$past(cmd.rd)] == ($past(a_val) & ~$past(cmd.imm)))
        else $error("bit clear wrong");
    test_keep_a: assert property (
        acc && !load_en && cmd.op == op_test_zero_negative |=>
            regs[$past(cmd.rd)] == $past(a_val) &&
            sreg_reg[FLAG_Z] == ($past(a_val) == 8'h00))
        else $error("test altered register");
    jump_z_a: assert property (
        acc && cmd.op == op_indirect_jump |=> pc_reg == $past(z_ptr) &&
            sreg_reg == $past(sreg_reg) ##0 hold_one)
        else $error("indirect jump wrong");
    call_rel_a: assert property (
        acc && cmd.op == op_relative_call |=>
            pc_reg == 16'($past(pc_reg) + $past(ofs_ext) + 16'h0001) &&
            push_valid ##0 hold_two)
        else $error("relative call wrong");
    skip_eq_a: assert property (
        acc && skip && next_two_word |=>
            pc_reg == 16'($past(pc_reg) + 16'h0003) ##0 hold_two)
        else $error("skip wrong");
    cmp_keep_a: assert property (
        acc && !load_en && cmd.op == op_compare_immediate |=>
            regs[$past(cmd.rd)] == $past(a_val) &&
            sreg_reg[FLAG_Z] == ($past(a_val) == $past(cmd.imm)))
        else $error("compare wrong");
endmodule : iab_core

// *** test/test_iab_core.sv ***
`timescale 1ns/1ps
module test_iab_core;
    import iab_pkg::*;
    logic clk_sys;
    logic arst_n;
    logic cmd_valid;
    iab_cmd_s cmd;
    logic next_two_word;
    logic cmd_ready;
    logic load_en;
    logic [REG_AW-1:0] load_addr;
    logic [DATA_W-1:0] load_data;
    logic [REG_AW-1:0] peek_addr;
    logic [DATA_W-1:0] peek_data;
    logic [PC_W-1:0] pc;
    logic [7:0] sreg;
    logic push_valid;
    logic [PC_W-1:0] push_pc;
    logic [7:0] m [REG_N];
    logic [7:0] ms;
    logic [15:0] mp;
    int mismatches;
    int num_checks;
    // register preload, {index, value}; r27:r26 = 8000 for the signed edge
    localparam logic [12:0] LOADS [10] = '{13'h005a, 13'h017f, 13'h0201,
        13'h0380, 13'h140f, 13'h18ff, 13'h19ff, 13'h1b80, 13'h1e34, 13'h1f12};

    iab_core u_iab_core (.clk_sys(clk_sys), .arst_n(arst_n),
        .cmd_valid(cmd_valid), .cmd(cmd), .next_two_word(next_two_word),
        .cmd_ready(cmd_ready), .load_en(load_en), .load_addr(load_addr),
        .load_data(load_data), .peek_addr(peek_addr), .peek_data(peek_data),
        .pc(pc), .sreg(sreg), .push_valid(push_valid), .push_pc(push_pc));

    // free-running system clock, 8 ns period
    always #4 clk_sys = ~clk_sys;

    task automatic give_verdict();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // address set on one falling edge, data read on the next; no command
    // is offered meanwhile, so the entry cannot move under the read
    task automatic peek(input logic [4:0] a);
        peek_addr = a;
        @(negedge clk_sys);
        chk({8'h00, peek_data}, {8'h00, m[a]});
    endtask : peek

    // add/sub flags; borrow and half borrow reuse the carry form on ~a, ~r
    function automatic logic [7:0] arith(input logic [7:0] s, a, b, r,
                                         input logic sb);
        logic [7:0] x;
        logic [7:0] y;
        x = sb ? ~a : a;
        y = sb ? ~r : r;
        arith = s;
        arith[FLAG_C] = x[7] & b[7] | b[7] & ~y[7] | ~y[7] & x[7];
        arith[FLAG_H] = x[3] & b[3] | b[3] & ~y[3] | ~y[3] & x[3];
        arith[FLAG_V] = (a[7] ^ b[7] ^ ~sb) & (a[7] ^ r[7]);
        arith[FLAG_N] = r[7];
        arith[FLAG_Z] = (r == 8'h00);
    endfunction : arith

    // one command: model it, issue it, offer junk while stalled, compare
    task automatic run(input iab_op_e op, input logic [4:0] rd, rr,
                       input logic [7:0] imm, input logic [11:0] ofs,
                       input logic ntw);
        logic [7:0] a, b, r, s;
        logic [15:0] w, rw, np;
        logic ci, sb, push;
        int n, xtra;
        a = m[rd];
        b = (op inside {op_and_with_constant, op_or_with_constant,
            op_set_bits_mask, op_clear_bits_mask, op_subtract_constant,
            op_subtract_constant_with_borrow, op_compare_immediate}) ?
            imm : m[rr];
        b = (op == op_test_zero_negative) ? a : b;
        ci = (op inside {op_add_carry, op_subtract_with_borrow,
            op_subtract_constant_with_borrow, op_compare_with_carry}) & ms[0];
        sb = !(op inside {op_add, op_add_carry});
        s = ms;
        np = mp + 16'h0001;
        xtra = 0;
        push = 1'b0;
        case (op)
            op_add_immediate_word, op_subtract_immediate_word: begin
                w = {m[rd | 5'h01], m[rd & 5'h1e]};
                sb = (op == op_subtract_immediate_word);
                rw = sb ? w - {10'h000, imm[5:0]} : w + {10'h000, imm[5:0]};
                s[FLAG_C] = sb ? rw[15] & ~w[15] : ~rw[15] & w[15];
                s[FLAG_V] = sb ? w[15] & ~rw[15] : ~w[15] & rw[15];
                s[FLAG_N] = rw[15];
                s[FLAG_S] = rw[15] ^ s[FLAG_V];
                s[FLAG_Z] = (rw == 16'h0000);
                m[rd | 5'h01] = rw[15:8];
                m[rd & 5'h1e] = rw[7:0];
                xtra = 1;
            end
            op_indirect_jump, op_indirect_call, op_relative_call: begin
                np = {m[31], m[30]};
                if (op == op_relative_call) begin
                    np = mp + {{4{ofs[11]}}, ofs} + 16'h0001;
                end
                push = (op != op_indirect_jump);
                xtra = push ? 2 : 1;
            end
            op_compare_skip_equal: if (a == m[rr]) begin
                np = mp + (ntw ? 16'h0003 : 16'h0002);
                xtra = ntw ? 2 : 1;
            end
            op_and, op_and_with_constant, op_or, op_or_with_constant,
            op_exclusive_or_registers, op_set_bits_mask, op_clear_bits_mask,
            op_test_zero_negative: begin
                r = a & b;
                if (op inside {op_or, op_or_with_constant,
                    op_set_bits_mask}) begin
                    r = a | b;
                end
                r = (op == op_exclusive_or_registers) ? a ^ b : r;
                r = (op == op_clear_bits_mask) ? a & (8'hff - b) : r;
                s[FLAG_Z] = (r == 8'h00);
                s[FLAG_N] = r[7];
                s[FLAG_V] = 1'b0;
                m[rd] = r;
            end
            default: begin
                r = sb ? a - b - {7'h00, ci} : a + b + {7'h00, ci};
                s = arith(s, a, b, r, sb);
                if (!(op inside {op_compare, op_compare_with_carry,
                    op_compare_immediate})) begin
                    m[rd] = r;
                end
            end
        endcase
        cmd_valid = 1'b1;
        cmd = '{op: op, rd: rd, rr: rr, imm: imm, ofs: ofs};
        next_two_word = ntw;
        @(negedge clk_sys);
        chk({15'h0000, push_valid}, {15'h0000, push});
        chk(push ? push_pc : 16'h0, push ? mp + 16'h1 : 16'h0);
        // a refused command must leave r0 and the flags alone
        n = 0;
        while (cmd_ready !== 1'b1 && n < 8) begin
            cmd = '{op: op_clear_bits_mask, rd: 5'h00, rr: 5'h00,
                imm: 8'hff, ofs: 12'h000};
            n++;
            @(negedge clk_sys);
        end
        cmd_valid = 1'b0;
        chk(n[15:0], xtra[15:0]);
        if (n == 8) begin
            give_verdict();
        end
        mp = np;
        ms = s;
        chk(pc, mp);
        chk({8'h00, sreg}, {8'h00, ms});
        peek(rd);
        peek(rd ^ 5'h01);
        peek(5'h00);
    endtask : run

    // reset, preload, directed edges, then every opcode in four passes
    initial begin
        clk_sys = 1'b0;
        arst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        next_two_word = 1'b0;
        load_en = 1'b0;
        load_addr = '0;
        load_data = '0;
        peek_addr = '0;
        mismatches = 0;
        num_checks = 0;
        ms = SREG_RESET;
        mp = PC_RESET;
        foreach (m[i]) m[i] = REG_RESET;
        repeat (10) @(negedge clk_sys);
        chk(pc, 16'h0000);
        chk({8'h00, sreg}, 16'h0000);
        chk({14'h0, cmd_ready, push_valid}, 16'h0002);
        arst_n = 1'b1;
        load_en = 1'b1;
        foreach (LOADS[i]) begin
            load_addr = LOADS[i][12:8];
            load_data = LOADS[i][7:0];
            m[LOADS[i][12:8]] = LOADS[i][7:0];
            @(negedge clk_sys);
        end
        load_en = 1'b0;
        run(op_add, 5'd1, 5'd2, 8'h00, 12'h0, 1'b0);
        run(op_add, 5'd3, 5'd3, 8'h00, 12'h0, 1'b0);
        run(op_subtract_with_borrow, 5'd2, 5'd1, 8'h0, 12'h0, 1'b0);
        run(op_add_carry, 5'd2, 5'd2, 8'h00, 12'h0, 1'b0);
        run(op_subtract_constant_with_borrow, 5'd20, 5'd0, 8'h10, 12'h0,
            1'b0);
        run(op_add_immediate_word, 5'd24, 5'd0, 8'hff, 12'h0, 1'b0);
        run(op_subtract_immediate_word, 5'd26, 5'd0, 8'h01, 12'h0,
            1'b0);
        run(op_subtract_immediate_word, 5'd28, 5'd0, 8'h01, 12'h0,
            1'b0);
        run(op_clear_bits_mask, 5'd1, 5'd0, 8'h0f, 12'h0, 1'b0);
        run(op_exclusive_or_registers, 5'd1, 5'd1, 8'h0, 12'h0,
            1'b0);
        run(op_compare_with_carry, 5'd1, 5'd3, 8'h0, 12'h0, 1'b0);
        run(op_compare_skip_equal, 5'd2, 5'd2, 8'h0, 12'h0, 1'b1);
        run(op_compare_skip_equal, 5'd2, 5'd1, 8'h0, 12'h0, 1'b0);
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i <= 8'h16; i++) begin
                run(iab_op_e'(i[4:0]), 5'd24, p[0] ? 5'd24 : 5'd20,
                    8'h3c + 8'(p * 81), p[1] ? 12'h800 : 12'h005,
                    p[1]);
            end
        end
        cmd_valid = 1'b0;
        @(negedge clk_sys);
        give_verdict();
    end
endmodule : test_iab_core
